// File: imt_core.sv
// Two-wire bus master unit with Avalon-MM register slave.
// Assumes open-drain pads outside: an enable pulls the line low.
`timescale 1ns/100ps
`default_nettype none
`include "imt_map.svh"
module imt_core import imt_pkg::*; (
  input wire logic clk, // System clock, 50 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic [3:0] address, // Byte address
  input wire logic read, // Read request
  input wire logic write, // Write request
  input wire logic [31:0] writedata, // Write data
  input wire logic [3:0] byteenable, // Byte lanes of a write
  output logic [31:0] readdata, // Read data, registered
  output logic waitrequest, // Stall until answer
  input wire logic scl_in, // Serial clock line level
  output logic scl_out, // Serial clock drive value, always low
  output logic scl_oe, // Pull serial clock low
  input wire logic sda_in, // Serial data line level
  output logic sda_out, // Serial data drive value, always low
  output logic sda_oe // Pull serial data low
);
  imt_state_t state_r;
  imt_mode_t mode_r;
  imt_kind_t kind_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [7:0] shift_r;
  logic [7:0] status_r;
  logic [7:0] data_r;
  logic [31:0] readdata_r;
  logic scl_oe_r, sda_oe_r, rep_r, ack_r, done_r, stop_clr_r, rx_load_r;
  logic flag_r, ack_en_r, start_r, stop_r, wcol_r, en_r, ie_r;
  logic resp_r, busy_r, sda_d_r;
  logic [1:0] lines_s;
  logic scl_s, sda_s, tick, run, stretch, rx_data, is_addr, go;
  logic ctl_wr, dat_wr;
  logic [7:0] byte_code;
  logic [7:0] ctrl_rd;

  // Pin synchronisers and quarter-bit timer
  imt_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .async_in({scl_in, sda_in}),
    .sync_out(lines_s)
  );
  assign scl_s = lines_s[1];
  assign sda_s = lines_s[0];

  imt_tick u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .run(run),
    .tick(tick)
  );

  // Bus slave: one wait state, writes land when waitrequest is low
  assign waitrequest = (read || write) && !resp_r;
  assign ctl_wr = write && resp_r && byteenable[0] &&
                  address == `IMT_OFS_CTRL;
  assign dat_wr = write && resp_r && byteenable[0] &&
                  address == `IMT_OFS_DATA;
  assign readdata = readdata_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resp_r <= 1'b0;
    end else if (ce) begin
      resp_r <= (read || write) && !resp_r;
    end
  end

  // Control register image; reserved bit 1 reads zero
  assign ctrl_rd = {flag_r, ack_en_r, start_r, stop_r, wcol_r, en_r,
                    1'b0, ie_r};

  // Read data captured on the first cycle of a read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      readdata_r <= 32'h0000_0000;
    end else if (ce && read && !resp_r) begin
      case (address)
        `IMT_OFS_CTRL: readdata_r <= {24'h000000, ctrl_rd};
        `IMT_OFS_STATUS: readdata_r <= {24'h000000, status_r};
        `IMT_OFS_DATA: readdata_r <= {24'h000000, data_r};
        default: readdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Completion flag: hardware set wins over a software clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (ce) begin
      if (done_r) begin
        flag_r <= 1'b1;
      end else if (ctl_wr && writedata[`IMT_B_FLAG]) begin
        flag_r <= 1'b0;
      end
    end
  end

  // Software control bits; stop self-clears once issued
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {ack_en_r, start_r, stop_r, en_r, ie_r} <= 5'h00;
    end else if (ce) begin
      if (ctl_wr) begin
        ack_en_r <= writedata[`IMT_B_ACKEN];
        start_r <= writedata[`IMT_B_START];
        stop_r <= writedata[`IMT_B_STOP];
        en_r <= writedata[`IMT_B_EN];
        ie_r <= writedata[`IMT_B_IE];
      end else if (stop_clr_r) begin
        stop_r <= 1'b0;
      end
    end
  end

  // Data register: received bytes load at byte end and win; other bus writes load only while flag is high, else collision
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_r <= `IMT_RST_DATA;
      wcol_r <= 1'b0;
    end else if (ce) begin
      if (rx_load_r) begin
        data_r <= shift_r;
      end else if (dat_wr && flag_r) begin
        data_r <= writedata[7:0];
        wcol_r <= 1'b0;
      end else if (dat_wr) begin
        wcol_r <= 1'b1;
      end
    end
  end

  // Bus busy tracking from START and STOP seen on the lines
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      sda_d_r <= 1'b1;
    end else if (ce) begin
      sda_d_r <= sda_s;
      if (scl_s && sda_d_r && !sda_s) begin
        busy_r <= 1'b1;
      end else if (scl_s && !sda_d_r && sda_s) begin
        busy_r <= 1'b0;
      end
    end
  end

  // Engine helpers
  assign rx_data = (kind_r == BK_DATA) && (mode_r == MD_RX);
  assign is_addr = (status_r == `IMT_ST_START) ||
                   (status_r == `IMT_ST_REP);
  assign go = !flag_r && !done_r;
  assign stretch = !scl_oe_r && !scl_s && (ph_r == 2'h1);
  assign run = (state_r == ST_START || state_r == ST_BIT ||
                state_r == ST_STOP) && !stretch;

  // Status after a byte: acknowledge seen as a low line
  always_comb begin
    byte_code = `IMT_ST_IDLE;
    if (kind_r == BK_ADDR && mode_r == MD_TX) begin
      byte_code = ack_r ? `IMT_ST_AW_ACK : `IMT_ST_AW_NACK;
    end else if (kind_r == BK_ADDR) begin
      byte_code = ack_r ? `IMT_ST_AR_ACK : `IMT_ST_AR_NACK;
    end else if (mode_r == MD_TX) begin
      byte_code = ack_r ? `IMT_ST_D_ACK : `IMT_ST_D_NACK;
    end else begin
      byte_code = ack_r ? `IMT_ST_RD_ACK : `IMT_ST_RD_NACK;
    end
  end

  // Serial engine: START, bytes, STOP, hold and lost-arbitration
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      mode_r <= MD_SLAVE;
      kind_r <= BK_ADDR;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      status_r <= `IMT_ST_IDLE;
      {scl_oe_r, sda_oe_r, rep_r, ack_r} <= 4'h0;
      {done_r, stop_clr_r, rx_load_r} <= 3'h0;
    end else if (ce) begin
      done_r <= 1'b0;
      stop_clr_r <= 1'b0;
      rx_load_r <= 1'b0;
      if (!en_r) begin
        state_r <= ST_IDLE;
        mode_r <= MD_SLAVE;
        scl_oe_r <= 1'b0;
        sda_oe_r <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            rep_r <= 1'b0;
            if (start_r && go) begin
              state_r <= ST_WAIT_FREE;
            end
          end
          ST_WAIT_FREE: begin
            if (!busy_r && scl_s && sda_s) begin
              state_r <= ST_START;
              ph_r <= 2'h0;
              sda_oe_r <= 1'b0;
            end
          end
          ST_START: begin
            if (tick) begin
              ph_r <= ph_r + 2'h1;
              if (ph_r == 2'h0) begin
                scl_oe_r <= 1'b0;
              end else if (ph_r == 2'h1) begin
                sda_oe_r <= 1'b1;
              end else if (ph_r == 2'h3) begin
                scl_oe_r <= 1'b1;
                state_r <= ST_HOLD;
                done_r <= 1'b1;
                status_r <= rep_r ? `IMT_ST_REP : `IMT_ST_START;
              end
            end
          end
          ST_BIT: begin
            if (tick) begin
              ph_r <= ph_r + 2'h1;
              if (ph_r == 2'h0) begin
                scl_oe_r <= 1'b0;
              end else if (ph_r == 2'h1) begin
                if (bit_r == 4'h8) begin
                  ack_r <= !sda_s;
                end else begin
                  shift_r <= {shift_r[6:0], sda_s};
                  if (!rx_data && !sda_oe_r && !sda_s) begin
                    state_r <= ST_LOST;
                    mode_r <= MD_SLAVE;
                    scl_oe_r <= 1'b0;
                    sda_oe_r <= 1'b0;
                    done_r <= 1'b1;
                    status_r <= `IMT_ST_ARB;
                  end
                end
              end else if (ph_r == 2'h2) begin
                scl_oe_r <= 1'b1;
              end else if (bit_r == 4'h8) begin
                state_r <= ST_HOLD;
                sda_oe_r <= 1'b0;
                done_r <= 1'b1;
                status_r <= byte_code;
                rx_load_r <= rx_data;
              end else begin
                bit_r <= bit_r + 4'h1;
                if (bit_r == 4'h7) begin
                  sda_oe_r <= rx_data && ack_en_r;
                end else begin
                  sda_oe_r <= !rx_data && !shift_r[7];
                end
              end
            end
          end
          ST_STOP: begin
            if (tick) begin
              ph_r <= ph_r + 2'h1;
              if (ph_r == 2'h0) begin
                scl_oe_r <= 1'b0;
              end else if (ph_r == 2'h1) begin
                sda_oe_r <= 1'b0;
              end else if (ph_r == 2'h3) begin
                rep_r <= 1'b0;
                status_r <= `IMT_ST_IDLE;
                state_r <= start_r ? ST_WAIT_FREE : ST_IDLE;
              end
            end
          end
          ST_HOLD: begin
            if (go) begin
              ph_r <= 2'h0;
              if (stop_r) begin
                state_r <= ST_STOP;
                mode_r <= MD_SLAVE;
                sda_oe_r <= 1'b1;
                stop_clr_r <= 1'b1;
              end else if (start_r) begin
                state_r <= ST_START;
                sda_oe_r <= 1'b0;
                rep_r <= 1'b1;
              end else begin
                state_r <= ST_BIT;
                bit_r <= 4'h0;
                shift_r <= data_r;
                if (is_addr) begin
                  kind_r <= BK_ADDR;
                  mode_r <= data_r[0] ? MD_RX : MD_TX;
                  sda_oe_r <= !data_r[7];
                end else begin
                  kind_r <= BK_DATA;
                  sda_oe_r <= (mode_r != MD_RX) && !data_r[7];
                end
              end
            end
          end
          ST_LOST: begin
            if (go) begin
              rep_r <= 1'b0;
              state_r <= start_r ? ST_WAIT_FREE : ST_IDLE;
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Open-drain pins: only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;

  // Checks on the engine
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !ce);

  property p_hold_scl;
    flag_r && state_r == ST_HOLD |-> scl_oe;
  endproperty
  a_hold_scl: assert property (p_hold_scl)
    else $error("clock not held low while flag set");

  property p_suspend;
    flag_r && en_r |=> $stable(state_r) && $stable(ph_r);
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("engine moved while flag set");

  property p_start_code;
    state_r == ST_START && tick && ph_r == 2'h3 && en_r |=>
      status_r inside {`IMT_ST_START, `IMT_ST_REP} ##1 flag_r;
  endproperty
  a_start_code: assert property (p_start_code)
    else $error("START not reported with 08 or 10");

  property p_wcol;
    dat_wr && !flag_r && !rx_load_r |=> wcol_r && $stable(data_r);
  endproperty
  a_wcol: assert property (p_wcol)
    else $error("data write with flag low not discarded");

  property p_stop_clear;
    state_r == ST_HOLD && go && stop_r && en_r && !ctl_wr |=>
      state_r == ST_STOP ##1 (!stop_r || $past(ctl_wr));
  endproperty
  a_stop_clear: assert property (p_stop_clear)
    else $error("stop bit not cleared after STOP issued");

  property p_addr_code;
    $rose(flag_r) && kind_r == BK_ADDR && $past(mode_r, 2) == MD_TX &&
      !is_addr |-> status_r inside {`IMT_ST_AW_ACK, `IMT_ST_AW_NACK,
                                    `IMT_ST_ARB};
  endproperty
  a_addr_code: assert property (p_addr_code)
    else $error("bad status after write address");

  property p_ack_release;
    state_r == ST_BIT && bit_r == 4'h8 && !rx_data |-> !sda_oe_r;
  endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("data line driven during slave acknowledge");

  property p_lost;
    state_r == ST_LOST |-> !scl_oe_r && !sda_oe_r && status_r ==
      `IMT_ST_ARB;
  endproperty
  a_lost: assert property (p_lost)
    else $error("bus not released after arbitration loss");

  property p_stop_lines;
    state_r == ST_STOP && ph_r == 2'h2 |-> !sda_oe_r && !scl_oe_r;
  endproperty
  a_stop_lines: assert property (p_stop_lines)
    else $error("STOP condition not completed");

  property p_free_bus;
    state_r == ST_WAIT_FREE ##1 state_r == ST_START |->
      !$past(busy_r);
  endproperty
  a_free_bus: assert property (p_free_bus)
    else $error("START issued on a busy bus");

  c_start: cover property ($rose(flag_r) && status_r == `IMT_ST_START);
  c_data_ack: cover property ($rose(flag_r) && status_r == `IMT_ST_D_ACK);
  c_stop: cover property (state_r == ST_STOP ##1 state_r == ST_IDLE);
  c_arb: cover property (state_r == ST_LOST);
endmodule
`default_nettype wire

// File: imt_map.svh
// Register offsets, field positions, status codes and timing counts
// for the two-wire master transmitter. Included by the core module.
`ifndef IMT_MAP_SVH
`define IMT_MAP_SVH

// Register byte offsets on the bus
`define IMT_OFS_CTRL 4'h0
`define IMT_OFS_STATUS 4'h4
`define IMT_OFS_DATA 4'h8

// Control register bit positions
`define IMT_B_FLAG 7
`define IMT_B_ACKEN 6
`define IMT_B_START 5
`define IMT_B_STOP 4
`define IMT_B_WCOL 3
`define IMT_B_EN 2
`define IMT_B_IE 0

// Reset values
`define IMT_RST_CTRL 8'h00
`define IMT_RST_DATA 8'hFF

// Status codes
`define IMT_ST_START 8'h08
`define IMT_ST_REP 8'h10
`define IMT_ST_AW_ACK 8'h18
`define IMT_ST_AW_NACK 8'h20
`define IMT_ST_D_ACK 8'h28
`define IMT_ST_D_NACK 8'h30
`define IMT_ST_ARB 8'h38
`define IMT_ST_AR_ACK 8'h40
`define IMT_ST_AR_NACK 8'h48
`define IMT_ST_RD_ACK 8'h50
`define IMT_ST_RD_NACK 8'h58
`define IMT_ST_IDLE 8'hF8

// Timing: bit period in ns, clock period in ns, quarter bit in cycles
`define IMT_BIT_NS 10000
`define IMT_CLK_NS 20
`define IMT_QTR_CYC ((`IMT_BIT_NS / 4 + `IMT_CLK_NS - 1) / `IMT_CLK_NS)

`endif

// File: imt_pkg.sv
// Types shared by the two-wire master transmitter modules.
// Assumes nothing beyond a SystemVerilog compiler.
package imt_pkg;
  // Engine sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT_FREE, ST_START, ST_BIT, ST_STOP, ST_HOLD, ST_LOST
  } imt_state_t;
  // Operating mode of the unit
  typedef enum logic [1:0] {MD_SLAVE, MD_TX, MD_RX} imt_mode_t;
  // Kind of byte on the wire
  typedef enum logic {BK_ADDR, BK_DATA} imt_kind_t;
endpackage

// File: imt_slave_model.sv
// Behavioural slave receiver that sits on the two-wire bus.
// Assumes pull-ups on both lines; a high pull output drives a line low.
`timescale 1ns/100ps
`default_nettype none
module imt_slave_model #(
  parameter logic [6:0] ADDR = 7'h3A // Own target address
) (
  input wire logic scl, // Clock line level
  input wire logic sda, // Data line level
  input wire logic nack_data, // Refuse data bytes
  input wire logic slow, // Stretch the clock after each bit
  output logic scl_pull, // Pull clock line low
  output logic sda_pull, // Pull data line low
  output logic [7:0] last_byte, // Last data byte taken
  output logic last_dir, // Direction bit of last address
  output int n_stop // STOP conditions seen
);
  logic [7:0] sh;
  int bitcnt;
  logic on, first, seen;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    last_byte = 8'h00;
    last_dir = 1'b0;
    n_stop = 0;
    bitcnt = 0;
    on = 1'b0;
    first = 1'b0;
    seen = 1'b0;
    sh = 8'h00;
  end
  // START restarts framing, STOP ends it; the unknown-to-high
  // step of the lines at power-up is not counted as a STOP
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      bitcnt = 0;
      first = 1'b1;
      on = 1'b1;
      seen = 1'b1;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1 && seen) begin
      n_stop++;
      on = 1'b0;
      seen = 1'b0;
    end
  end
  // Shift in eight bits, MSB first
  always @(posedge scl) begin
    if (on && bitcnt < 8) begin
      sh = {sh[6:0], sda};
      bitcnt++;
    end
  end
  // Answer on the ninth bit, then release the line to its pull-up
  always @(negedge scl) begin
    if (on && bitcnt == 8) begin
      if (first) begin
        last_dir = sh[0];
        on = (sh[7:1] == ADDR);
        sda_pull = on;
      end else begin
        last_byte = sh;
        sda_pull = !nack_data;
      end
      bitcnt = 9;
    end else if (bitcnt == 9) begin
      sda_pull = 1'b0;
      bitcnt = 0;
      first = 1'b0;
    end
    if (slow) begin
      scl_pull = 1'b1;
      #7000; // Longer than the master's own low time, so it stretches
      scl_pull = 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: imt_sync.sv
// Two-flop synchronisers for the bus clock and data line inputs.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module imt_sync import imt_pkg::*; (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic ce, // Clock enable
  input wire logic [1:0] async_in, // Raw pin levels
  output logic [1:0] sync_out // Synchronised levels
);
  logic [1:0] meta_r;
  logic [1:0] sync_r;

  // One synchroniser per line; idle bus level is high
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        meta_r[i] <= 1'b1;
        sync_r[i] <= 1'b1;
      end else if (ce) begin
        meta_r[i] <= async_in[i];
        sync_r[i] <= meta_r[i];
      end
    end
  end

  assign sync_out = sync_r;
endmodule
`default_nettype wire

// File: imt_tick.sv
// Quarter-bit timer for the serial engine.
// Assumes run is low whenever the engine is not timing a phase.
`timescale 1ns/100ps
`default_nettype none
`include "imt_map.svh"
module imt_tick import imt_pkg::*; (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic ce, // Clock enable
  input wire logic run, // Count while high, restart when low
  output logic tick // One-cycle pulse per quarter bit
);
  localparam logic [7:0] QTR_LAST = 8'(`IMT_QTR_CYC - 1);
  logic [7:0] cnt_r;

  // Counter restarts whenever run drops, so stretched clocks re-time
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
    end else if (ce) begin
      if (!run || cnt_r == QTR_LAST) begin
        cnt_r <= 8'h00;
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

  assign tick = run && (cnt_r == QTR_LAST);
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench for the two-wire master transmitter core.
// Assumes the behavioural slave model and open-drain lines with pull-ups.
`timescale 1ns/100ps
`default_nettype none
`include "imt_map.svh"
module tb;
  logic clk, rst_n, ce, read, write, waitrequest;
  logic [3:0] address, byteenable;
  logic [31:0] writedata, readdata;
  logic scl_out, scl_oe, sda_out, sda_oe, s_scl, s_sda, scl_w, sda_w;
  logic nack_data, slow, last_dir, rival;
  logic [7:0] last_byte, v, d;
  int n_stop, n_errors, compares;
  localparam logic [6:0] SADDR = 7'h3A;

  // Wired-AND lines with pull-ups
  assign scl_w = ~(scl_oe | s_scl);
  assign sda_w = ~(sda_oe | s_sda | rival);

  imt_core imt_core_i (.clk(clk), .rst_n(rst_n), .ce(ce),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
  imt_slave_model #(.ADDR(SADDR)) imt_slave_model_i (.scl(scl_w),
    .sda(sda_w), .nack_data(nack_data), .slow(slow), .scl_pull(s_scl),
    .sda_pull(s_sda), .last_byte(last_byte), .last_dir(last_dir),
    .n_stop(n_stop));

  // Expected status code after a byte
  function automatic logic [7:0] exp_code(input logic is_addr,
    input logic rd_dir, input logic acked);
    if (!is_addr) return acked ? `IMT_ST_D_ACK : `IMT_ST_D_NACK;
    if (rd_dir) return acked ? `IMT_ST_AR_ACK : `IMT_ST_AR_NACK;
    return acked ? `IMT_ST_AW_ACK : `IMT_ST_AW_NACK;
  endfunction

  task automatic finish_test;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] e,
    input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
    input logic [7:0] dv, output logic [7:0] qv);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= {24'h000000, dv};
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk("waitrequest", 8'h00, 8'hFF);
    qv = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] dv);
    logic [7:0] q;
    bus(1'b1, a, dv, q);
  endtask

  // Poll the flag, then check the masked code and the stalled bus
  task automatic wait_flag(input string what, input logic [7:0] code);
    logic [7:0] q, held;
    int n;
    q = 8'h00;
    held = {7'h00, code != `IMT_ST_ARB};
    n = 0;
    while (q[7] !== 1'b1 && n < 8000) begin
      bus(1'b0, `IMT_OFS_CTRL, 8'h00, q);
      n++;
    end
    chk("flag set", 8'h80, q & 8'h80);
    bus(1'b0, `IMT_OFS_STATUS, 8'h00, q);
    chk(what, code, q & 8'hF8);
    chk("clock held", held, {7'h00, scl_oe});
    repeat (200) @(posedge clk);
    bus(1'b0, `IMT_OFS_STATUS, 8'h00, q);
    chk("status frozen", code, q & 8'hF8);
    chk("clock still held", held, {7'h00, scl_oe});
  endtask

  // Send one byte: load data register, then clear the flag
  task automatic send(input logic [7:0] b);
    wreg(`IMT_OFS_DATA, b);
    wreg(`IMT_OFS_CTRL, 8'h84);
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #1600000;
    n_errors++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h00000000;
    byteenable = 4'hF;
    nack_data = 1'b0;
    slow = 1'b0;
    rival = 1'b0;
    n_errors = 0;
    compares = 0;
    v = 8'($urandom(87));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values and an unmapped address
    bus(1'b0, `IMT_OFS_CTRL, 8'h00, v);
    chk("ctrl reset", `IMT_RST_CTRL, v);
    bus(1'b0, `IMT_OFS_STATUS, 8'h00, v);
    chk("status reset", `IMT_ST_IDLE, v);
    bus(1'b0, `IMT_OFS_DATA, 8'h00, v);
    chk("data reset", `IMT_RST_DATA, v);
    bus(1'b0, 4'hC, 8'h00, v);
    chk("unmapped read", 8'h00, v);
    chk("drive values", 8'h00, {6'h00, scl_out, sda_out});
    $display("test reset done");
    // Data write while the flag is low
    wreg(`IMT_OFS_DATA, 8'h5A);
    bus(1'b0, `IMT_OFS_CTRL, 8'h00, v);
    chk("collision bit", 8'h08, v & 8'h08);
    bus(1'b0, `IMT_OFS_DATA, 8'h00, v);
    chk("data kept", `IMT_RST_DATA, v);
    $display("test collision done");
    // Write transfer with slow and refusing slave
    wreg(`IMT_OFS_CTRL, 8'hA4);
    wait_flag("start code", `IMT_ST_START);
    send({SADDR, 1'b0});
    wait_flag("write addr", exp_code(1'b1, 1'b0, 1'b1));
    chk("dir write", 8'h00, {7'h00, last_dir});
    slow = 1'b1;
    d = 8'($urandom);
    send(d);
    wait_flag("data ack", exp_code(1'b0, 1'b0, 1'b1));
    chk("byte seen", d, last_byte);
    nack_data = 1'b1;
    d = 8'($urandom);
    send(d);
    wait_flag("data nack", exp_code(1'b0, 1'b0, 1'b0));
    chk("byte seen", d, last_byte);
    slow = 1'b0;
    nack_data = 1'b0;
    wreg(`IMT_OFS_CTRL, 8'hB4);
    wait_flag("stop start", `IMT_ST_START);
    bus(1'b0, `IMT_OFS_CTRL, 8'h00, v);
    chk("stop bit auto", 8'h00, v & 8'h10);
    chk("stop count", 8'd1, n_stop[7:0]);
    d = {SADDR ^ (7'h01 + 7'($urandom % 126)), 1'b0};
    send(d);
    wait_flag("addr nack", exp_code(1'b1, 1'b0, 1'b0));
    $display("test write transfer done");
    // Repeated start, read address, stop
    wreg(`IMT_OFS_CTRL, 8'hA4);
    wait_flag("repeated start", `IMT_ST_REP);
    send({d[7:1], 1'b1});
    wait_flag("read addr", exp_code(1'b1, 1'b1, 1'b0));
    chk("dir read", 8'h01, {7'h00, last_dir});
    wreg(`IMT_OFS_CTRL, 8'h94);
    v = 8'h10;
    for (int n = 0; n < 2000 && v[4] !== 1'b0; n++) begin
      bus(1'b0, `IMT_OFS_CTRL, 8'h00, v);
    end
    chk("stop cleared", 8'h00, v & 8'h90);
    repeat (1000) @(posedge clk);
    chk("stop count", 8'd2, n_stop[7:0]);
    bus(1'b0, `IMT_OFS_STATUS, 8'h00, v);
    chk("idle status", `IMT_ST_IDLE, v & 8'hF8);
    chk("lines free", 8'h00, {6'h00, scl_oe, sda_oe});
    $display("test read address and stop done");
    // Arbitration lost to a rival holding the data line low
    wreg(`IMT_OFS_CTRL, 8'hA4);
    wait_flag("start again", `IMT_ST_START);
    rival <= 1'b1;
    send(8'hFE);
    wait_flag("arb lost", `IMT_ST_ARB);
    rival <= 1'b0;
    wreg(`IMT_OFS_CTRL, 8'hA4);
    wait_flag("start after loss", `IMT_ST_START);
    wreg(`IMT_OFS_CTRL, 8'h94);
    repeat (1000) @(posedge clk);
    chk("lines free", 8'h00, {6'h00, scl_oe, sda_oe});
    $display("test arbitration done");
    finish_test();
  end
endmodule
`default_nettype wire
